//--- enc_emu_pkg.sv
package enc_emu_pkg;

    // ==========================================================
    // encoder types at the feedback connector
    typedef enum logic [2:0] {
        ENC_G1, ENC_G2, ENC_G3, ENC_G4, ENC_R1, ENC_R2, ENC_R8
    } encoder_type_type;

    // ==========================================================
    // counts and widths
    localparam int ANGLE_W = 12;
    localparam int PPR_W = 12;
    localparam logic [PPR_W-1:0] PPR_BASE = 12'h400;
    localparam logic [PPR_W-1:0] PPR_G1 = 12'h800;
    localparam logic [PPR_W-1:0] PPR_G23 = 12'h800;
    localparam logic [PPR_W-1:0] PPR_G4 = 12'h400;
    localparam logic [PPR_W-1:0] RST_PPR = 12'h000;
    localparam logic [1:0] RST_POLE_PAIRS = 2'h0;

    // ==========================================================
    // bit positions in the synchronised pin vector
    localparam int SYN_W = 9;
    localparam int SYN_OA = 0;
    localparam int SYN_OB = 1;
    localparam int SYN_OZ = 2;
    localparam int SYN_AA = 3;
    localparam int SYN_AA_N = 4;
    localparam int SYN_AB = 5;
    localparam int SYN_AB_N = 6;
    localparam int SYN_AZ = 7;
    localparam int SYN_AZ_N = 8;

    // ==========================================================
    // type decoding
    function automatic logic is_resolver(input encoder_type_type t);
        return (t == ENC_R1) || (t == ENC_R2) || (t == ENC_R8);
    endfunction

    function automatic logic [1:0] pole_pairs_of(input encoder_type_type t);
        case (t)
            ENC_R1: return 2'h1;
            ENC_R2: return 2'h2;
            ENC_R8: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    function automatic logic [PPR_W-1:0] ppr_of(input encoder_type_type t);
        case (t)
            ENC_G1: return PPR_G1;
            ENC_G2, ENC_G3: return PPR_G23;
            ENC_G4: return PPR_G4;
            ENC_R1: return PPR_BASE;
            ENC_R2: return PPR_BASE + PPR_BASE;
            ENC_R8: return PPR_BASE + PPR_BASE + PPR_BASE;
            default: return RST_PPR;
        endcase
    endfunction

endpackage

//--- enc_reader.sv
`timescale 1ns/1ps
module enc_reader (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic a,
    input wire logic a_n,
    input wire logic b,
    input wire logic b_n,
    input wire logic z,
    input wire logic z_n,
    output logic [31:0] pos,
    output logic [31:0] zeros,
    output logic pair_err
);
    // ==========================================================
    // quadrature reader
    // decodes on every clock, so it keeps up with the fastest edge rate
    logic a_d;
    logic b_d;
    logic z_d;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_d <= 1'b0;
            b_d <= 1'b0;
            z_d <= 1'b0;
            pos <= 32'h0;
            zeros <= 32'h0;
            pair_err <= 1'b0;
        end else begin
            a_d <= a;
            b_d <= b;
            z_d <= z;
            if (clr) begin
                pos <= 32'h0;
                zeros <= 32'h0;
            end else begin
                if ((a ^ a_d) || (b ^ b_d)) begin
                    pos <= (a == b_d) ? pos + 32'h1 : pos - 32'h1;
                end
                if (z && !z_d) begin
                    zeros <= zeros + 32'h1;
                end
            end
            // sticky, so one bad cycle anywhere in the run is seen
            if ((a == a_n) || (b == b_n) || (z == z_n)) begin
                pair_err <= 1'b1;
            end
        end
    end
endmodule

//--- encoder_emulation.sv
`timescale 1ns/1ps
module encoder_emulation
    import enc_emu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire encoder_type_type encoder_type,
    input wire logic optical_feedback_build,
    input wire logic [ANGLE_W-1:0] resolver_angle,
    input wire logic opt_track_a,
    input wire logic opt_track_b,
    input wire logic opt_index,
    input wire logic aux_in_track_a_true,
    input wire logic aux_in_track_a_inverted,
    input wire logic aux_in_track_b_true,
    input wire logic aux_in_track_b_inverted,
    input wire logic aux_in_index_true,
    input wire logic aux_in_index_inverted,
    output logic emu_track_a_true,
    output logic emu_track_a_inverted,
    output logic emu_track_b_true,
    output logic emu_track_b_inverted,
    output logic emu_index_true,
    output logic emu_index_inverted,
    output logic [PPR_W-1:0] pulses_per_rev,
    output logic [1:0] pole_pairs,
    output logic optical_build,
    output logic aux_track_a,
    output logic aux_track_b,
    output logic aux_index,
    output logic aux_fault
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [SYN_W-1:0] s1;
        logic [SYN_W-1:0] s2;
        logic [SYN_W-1:0] s3;
        logic [SYN_W-1:0] stable;
        logic strap_taken;
        logic optical_build;
        logic [PPR_W-1:0] ppr;
        logic [1:0] pole_pairs;
        logic ea;
        logic ea_n;
        logic eb;
        logic eb_n;
        logic ez;
        logic ez_n;
        logic aux_a;
        logic aux_b;
        logic aux_z;
        logic aux_fault;
    } emu_state_type;

    emu_state_type st_r;
    emu_state_type st_nxt;
    logic [SYN_W-1:0] pins;
    logic [ANGLE_W-1:0] fcount;
    logic src_a;
    logic src_b;
    logic src_z;
    logic res_mode;

    assign pins = {aux_in_index_inverted, aux_in_index_true,
                   aux_in_track_b_inverted, aux_in_track_b_true,
                   aux_in_track_a_inverted, aux_in_track_a_true,
                   opt_index, opt_track_b, opt_track_a};

    assign res_mode = is_resolver(encoder_type);

    // ==========================================================
    // resolver angle to quadrature count; the angle is electrical,
    // so one count cycle repeats once per pole pair
    quad_follower #(
        .CNT_W(ANGLE_W)
    ) follower (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .follow_en(res_mode),
        .target(resolver_angle),
        .count_r(fcount)
    );

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        // pins come from outside: three stages, accepted when 2 and 3 agree
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < SYN_W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
        end

        // strap caught once, on the first enabled edge after reset
        if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            st_nxt.optical_build = optical_feedback_build;
        end

        st_nxt.ppr = ppr_of(encoder_type);
        st_nxt.pole_pairs = pole_pairs_of(encoder_type);

        // sources of the three emulated channels
        if (res_mode) begin
            src_a = fcount[1];
            src_b = fcount[1] ^ fcount[0];
            src_z = (fcount == '0);
        end else begin
            src_a = st_r.stable[SYN_OA];
            src_b = st_r.stable[SYN_OB];
            src_z = (encoder_type == ENC_G1) && st_r.stable[SYN_OZ];
        end
        // each track goes out as a true/inverted pair
        st_nxt.ea = src_a;
        st_nxt.ea_n = ~src_a;
        st_nxt.eb = src_b;
        st_nxt.eb_n = ~src_b;
        st_nxt.ez = src_z;
        st_nxt.ez_n = ~src_z;

        // aux input exists only on optical builds; resolver builds read zero
        if (st_r.optical_build) begin
            st_nxt.aux_a = st_r.stable[SYN_AA];
            st_nxt.aux_b = st_r.stable[SYN_AB];
            st_nxt.aux_z = st_r.stable[SYN_AZ];
            st_nxt.aux_fault = (st_r.stable[SYN_AA] == st_r.stable[SYN_AA_N])
                || (st_r.stable[SYN_AB] == st_r.stable[SYN_AB_N])
                || (st_r.stable[SYN_AZ] == st_r.stable[SYN_AZ_N]);
        end else begin
            st_nxt.aux_a = 1'b0;
            st_nxt.aux_b = 1'b0;
            st_nxt.aux_z = 1'b0;
            st_nxt.aux_fault = 1'b0;
        end
    end

    // ==========================================================
    // registers; complementary outputs start as a valid pair
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.ea_n <= 1'b1;
            st_r.eb_n <= 1'b1;
            st_r.ez_n <= 1'b1;
            st_r.ppr <= RST_PPR;
            st_r.pole_pairs <= RST_POLE_PAIRS;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign emu_track_a_true = st_r.ea;
    assign emu_track_a_inverted = st_r.ea_n;
    assign emu_track_b_true = st_r.eb;
    assign emu_track_b_inverted = st_r.eb_n;
    assign emu_index_true = st_r.ez;
    assign emu_index_inverted = st_r.ez_n;
    assign pulses_per_rev = st_r.ppr;
    assign pole_pairs = st_r.pole_pairs;
    assign optical_build = st_r.optical_build;
    assign aux_track_a = st_r.aux_a;
    assign aux_track_b = st_r.aux_b;
    assign aux_index = st_r.aux_z;
    assign aux_fault = st_r.aux_fault;

    // ==========================================================
    // checks
    pair_a_a: assert property (
        @(posedge clk) disable iff (rst)
        emu_track_a_true != emu_track_a_inverted)
        else $error("track a pair not complementary");

    pair_bz_a: assert property (
        @(posedge clk) disable iff (rst)
        (emu_track_b_true != emu_track_b_inverted) && (emu_index_true != emu_index_inverted))
        else $error("track b or index pair not complementary");

    ppr_select_a: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> (pulses_per_rev == ppr_of($past(encoder_type))))
        else $error("pulse count does not match encoder type");

    resolver_ppr_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && res_mode) |=> (pulses_per_rev == PPR_BASE * pole_pairs))
        else $error("resolver pulse count not pole pairs times base");

    optical_noindex_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !res_mode && (encoder_type != ENC_G1)) |=> !emu_index_true)
        else $error("index seen on optical type without index");

    resolver_index_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && res_mode) |=> (emu_index_true == ($past(fcount) == '0)))
        else $error("resolver index not at count zero");

    optical_pass_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !res_mode) |=> ((emu_track_a_true == $past(st_r.stable[SYN_OA]))
                               && (emu_track_b_true == $past(st_r.stable[SYN_OB]))))
        else $error("optical tracks not passed through");

    quad_gray_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && res_mode && $past(ce && res_mode))
            |=> !($changed(emu_track_a_true) && $changed(emu_track_b_true)))
        else $error("a and b changed together");

    aux_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !optical_build) |=> !(aux_track_a || aux_track_b || aux_index || aux_fault))
        else $error("aux input active on resolver build");

    sync_delay_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && res_mode) |=> (emu_track_a_true == $past(fcount[1])))
        else $error("emulated track lags more than one cycle");

endmodule

//--- encoder_emulation_bench.sv
`timescale 1ns/1ps
module encoder_emulation_bench;
    import enc_emu_pkg::*;
    typedef struct {int kind; logic [31:0] exp;} note_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clr = 1'b0;
    logic ce = 1'b1;
    encoder_type_type etype = ENC_R1;
    logic strap = 1'b0;
    logic [ANGLE_W-1:0] angle = 12'h000;
    logic [2:0] opt = 3'h0;
    logic [5:0] aux = 6'h2A;
    logic ta, ta_n, tb, tb_n, ti, ti_n, opb, aa, ab, az, af, perr;
    logic [PPR_W-1:0] ppr;
    logic [1:0] pp;
    logic [31:0] pos, zeros;
    note_type q[$];
    int num_errors = 0;
    int cmp_count = 0;
    int rn;
    logic r;

    // ==========================================================
    // instances
    encoder_emulation u_encoder_emulation (.clk(clk), .rst(rst), .ce(ce),
        .encoder_type(etype), .optical_feedback_build(strap), .resolver_angle(angle),
        .opt_track_a(opt[0]), .opt_track_b(opt[1]), .opt_index(opt[2]),
        .aux_in_track_a_true(aux[5]), .aux_in_track_a_inverted(aux[4]),
        .aux_in_track_b_true(aux[3]), .aux_in_track_b_inverted(aux[2]),
        .aux_in_index_true(aux[1]), .aux_in_index_inverted(aux[0]),
        .emu_track_a_true(ta), .emu_track_a_inverted(ta_n), .emu_track_b_true(tb),
        .emu_track_b_inverted(tb_n), .emu_index_true(ti), .emu_index_inverted(ti_n),
        .pulses_per_rev(ppr), .pole_pairs(pp), .optical_build(opb), .aux_track_a(aa),
        .aux_track_b(ab), .aux_index(az), .aux_fault(af));
    enc_reader u_enc_reader (.clk(clk), .rst(rst), .clr(clr), .a(ta), .a_n(ta_n), .b(tb),
        .b_n(tb_n), .z(ti), .z_n(ti_n), .pos(pos), .zeros(zeros), .pair_err(perr));

    // ==========================================================
    // helpers
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic note(input int kind, input logic [31:0] exp);
        q.push_back('{kind, exp});
    endtask

    function automatic logic [31:0] observe(input int kind);
        case (kind)
            0: return pos;
            1: return zeros;
            2: return 32'(ppr);
            3: return 32'(pp);
            4: return {31'h0, ta};
            5: return {31'h0, ti};
            6: return {29'h0, aa, ab, az};
            7: return {31'h0, af};
            8: return {31'h0, perr};
            9: return {31'h0, opb};
            default: return {31'h0, tb};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: kind mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic restart(input logic s);
        strap = s;
        rst = 1'b1;
        tick(10);
        rst = 1'b0;
        tick(2);
    endtask

    // angle walks one count a cycle, the rate the follower can track
    task automatic sweep(input int steps, input int dir);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        for (int i = 0; i < steps; i++) begin
            angle = angle + 12'(dir);
            tick(1);
        end
        tick(4);
    endtask

    // ==========================================================
    // result monitor
    initial begin : monitor
        note_type n;
        forever begin
            // outputs launched at the rising edge are settled by the falling edge
            @(negedge clk);
            while (q.size() > 0) begin
                n = q.pop_front();
                check(observe(n.kind), n.exp);
            end
        end
    end

    initial begin : watchdog
        repeat (100000) @(posedge clk);
        num_errors++;
        results();
    end

    // ==========================================================
    // scenarios
    initial begin : main
        void'($urandom(23));
        restart(1'b0);
        note(9, 32'h0);
        for (int t = 4; t < 7; t++) begin
            etype = encoder_type_type'(t);
            tick(2);
            note(2, 32'(1024 * (t - 3)));
            note(3, 32'(t - 3));
            sweep(4096 * (t - 3), 1);
            note(0, 32'(4096 * (t - 3)));
            note(1, 32'(t - 3));
        end
        rn = 1 + int'($urandom % 200);
        sweep(rn, -1);
        note(0, 32'(-rn));
        ce = 1'b0;
        angle = angle + 12'h5;
        tick(8);
        note(0, 32'(-rn));
        ce = 1'b1;
        tick(12);
        note(0, 32'(5 - rn));
        aux = 6'h3F;
        tick(8);
        note(6, 32'h0);
        note(7, 32'h0);
        tick(1);
        restart(1'b1);
        note(9, 32'h1);
        for (int t = 0; t < 4; t++) begin
            etype = encoder_type_type'(t);
            opt = 3'h7;
            tick(8);
            note(5, (t == 0) ? 32'h1 : 32'h0);
            note(2, (t == 3) ? 32'h400 : 32'h800);
            note(3, 32'h0);
            opt = 3'h0;
            tick(8);
        end
        for (int k = 0; k < 8; k++) begin
            r = 1'($urandom);
            opt = {1'b0, r, ~opt[0]};
            tick(4);
            note(4, {31'h0, ~opt[0]});
            tick(1);
            note(4, {31'h0, opt[0]});
            note(10, {31'h0, r});
            tick(3);
        end
        aux = 6'h2A;
        tick(8);
        note(6, 32'h7);
        note(7, 32'h0);
        aux = 6'h15;
        tick(8);
        note(6, 32'h0);
        aux = 6'h3A;
        tick(8);
        note(7, 32'h1);
        note(8, 32'h0);
        tick(2);
        results();
    end
endmodule

//--- quad_follower.sv
`timescale 1ns/1ps
module quad_follower
    import enc_emu_pkg::*;
#(
    parameter int CNT_W = ANGLE_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic follow_en,
    input wire logic [CNT_W-1:0] target,
    output logic [CNT_W-1:0] count_r
);

    // refused at elaboration: the gray decode needs two count bits plus a sign bit
    if (CNT_W < 3) begin : g_width_check
        $error("quad_follower: CNT_W must be at least 3");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } follow_state_type;

    follow_state_type st_r;
    follow_state_type st_nxt;
    logic [CNT_W-1:0] diff;

    // ==========================================================
    // one quadrature count per cycle along the shorter way round,
    // so a/b never skip a state however fast the shaft turns
    always_comb begin
        st_nxt = st_r;
        diff = target - st_r.cnt;
        if (follow_en && (diff != '0)) begin
            if (diff[CNT_W-1]) begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign count_r = st_r.cnt;

    // ==========================================================
    // checks
    single_step_a: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> ((st_r.cnt == $past(st_r.cnt)) || (st_r.cnt == $past(st_r.cnt) + 1'b1)
                || (st_r.cnt == $past(st_r.cnt) - 1'b1)))
        else $error("follower moved more than one count");

    keeps_moving_a: assert property (
        @(posedge clk) disable iff (rst)
        (ce && follow_en && (target != st_r.cnt)) |=> (st_r.cnt != $past(st_r.cnt)))
        else $error("follower stalled while behind");

endmodule
